/* File: loader_regs.svh */
`ifndef LOADER_REGS_SVH
`define LOADER_REGS_SVH
`define OP_WAKE 8'hAB
`define OP_FAST_READ 8'h0B
`define FLASH_START_ADDR 24'h00_0000
`define WAKE_BITS 6'd8
`define READ_HDR_BITS 6'd40
`define WAKE_WAIT_NS 30000
`define CLK_PERIOD_NS 25
`define RESET_HOLD_CYCLES 4
`define FIFO_DEPTH 32
`define MODE_ACTIVE 2'h0
`define MODE_PASSIVE 2'h1
`define MODE_JTAG 2'h2
`define MODE_MASK 2'h3
`endif

/* File: loader_pkg.sv */
package loader_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAKE = 3'b001,
        ST_WAIT = 3'b011,
        ST_CMD = 3'b010,
        ST_LOAD = 3'b110,
        ST_DONE = 3'b111
    } load_state_t;
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic mosi;
    } spi_out_t;
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } config_ram_wr_t;
endpackage

/* File: byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_state_t;
    fifo_state_t s_q, s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // handshake and pointers
    assign in_ready = s_q.cnt != (AW+1)'(DEPTH);
    assign out_valid = s_q.cnt != '0;
    assign out_data = mem[s_q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        s_d = s_q;
        if (push) s_d.wp = s_q.wp + 1'b1;
        if (pop) s_d.rp = s_q.rp + 1'b1;
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk) begin
        if (!rst_n) s_q <= '0;
        else s_q <= s_d;
        if (push) mem[s_q.wp] <= in_data;
    end
    a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count over depth");
endmodule

/* File: config_loader.sv */
`timescale 1ns/1ps
`include "loader_regs.svh"
module config_loader #(
    parameter int WAKE_WAIT_CYCLES = (`WAKE_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int IMAGE_BYTES = 1024,
    parameter int SCK_DIV = 2
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic CONFIG_RESET_N,
    input wire logic [1:0] MODE,
    output loader_pkg::spi_out_t SPI_OUT,
    input wire logic SPI_MISO,
    input wire logic PAS_SCK,
    input wire logic PAS_CS_N,
    input wire logic PAS_MOSI,
    input wire logic JTAG_VALID,
    input wire logic [7:0] JTAG_BYTE,
    output logic [15:0] MASK_ADDR,
    input wire logic [7:0] MASK_BYTE,
    output loader_pkg::config_ram_wr_t CONFIG_RAM_WR,
    output logic USER_MODE
);
    import loader_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        load_state_t st;
        logic [1:0] mode;
        logic [2:0] hold;
        logic creset_prev;
        logic [15:0] wait_cnt;
        logic [7:0] div;
        logic [5:0] bit_cnt;
        logic [39:0] shreg;
        logic [7:0] rx;
        logic [2:0] rx_bits;
        logic pas_sck_prev;
        logic [15:0] in_cnt;
        logic [15:0] out_cnt;
        logic mask_pend;
        spi_out_t spi;
        config_ram_wr_t wr;
        logic user;
    } core_state_t;
    core_state_t s_q, s_d;

    logic f_in_valid, f_in_ready, f_out_valid;
    logic [7:0] f_in_data, f_out_data;
    logic tick;

    // ****************************************
    // byte buffer between source and config_ram
    // ****************************************
    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) byte_fifo_inst (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(1'b1),
        .out_data(f_out_data)
    );

    // oscillator divider for serial clock half period
    assign tick = s_q.div == 8'(SCK_DIV - 1);

    // source mux into the buffer
    always_comb begin
        f_in_valid = 1'b0;
        f_in_data = s_q.rx;
        if (s_q.st == ST_LOAD && s_q.in_cnt != 16'(IMAGE_BYTES)) begin
            if (s_q.mode == `MODE_JTAG) begin
                f_in_valid = JTAG_VALID;
                f_in_data = JTAG_BYTE;
            end else if (s_q.mode == `MODE_MASK) begin
                f_in_valid = s_q.mask_pend;
                f_in_data = MASK_BYTE;
            end else begin
                f_in_valid = s_q.rx_bits == 3'd0 && s_q.bit_cnt == 6'd1;
            end
        end
    end

    // flash pins parked: deselected, clock low, data low
    function automatic spi_out_t spi_idle();
        return '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
    endfunction

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.wr.we = 1'b0;
        s_d.creset_prev = CONFIG_RESET_N;
        s_d.pas_sck_prev = PAS_SCK;
        s_d.div = tick ? 8'h00 : s_q.div + 8'h01;
        s_d.bit_cnt = 6'd0;
        // buffer drain to config_ram
        if (f_out_valid) begin
            s_d.wr.we = 1'b1;
            s_d.wr.addr = s_q.out_cnt;
            s_d.wr.data = f_out_data;
            s_d.out_cnt = s_q.out_cnt + 16'h0001;
        end
        if (f_in_valid && f_in_ready) s_d.in_cnt = s_q.in_cnt + 16'h0001;
        case (s_q.st)
            ST_IDLE: begin
                s_d.spi = spi_idle();
                if (CONFIG_RESET_N) s_d.hold = s_q.hold + 3'd1;
                else s_d.hold = 3'd0;
                if (CONFIG_RESET_N && s_q.hold == 3'(`RESET_HOLD_CYCLES)) begin
                    s_d.mode = MODE;
                    s_d.in_cnt = 16'h0000;
                    s_d.out_cnt = 16'h0000;
                    s_d.st = (MODE == `MODE_ACTIVE) ? ST_WAKE : ST_LOAD;
                    s_d.shreg = {`OP_WAKE, 32'h0};
                    s_d.bit_cnt = `WAKE_BITS;
                    // no partial byte carried over from an earlier load
                    s_d.rx = 8'h00;
                    s_d.rx_bits = 3'd0;
                    s_d.spi.cs_n = MODE != `MODE_ACTIVE;
                    // first wake bit settled before the first clock rise
                    s_d.spi.mosi = (MODE == `MODE_ACTIVE) && s_d.shreg[39];
                end
            end
            ST_WAKE, ST_CMD: begin
                s_d.bit_cnt = s_q.bit_cnt;
                if (tick) begin
                    if (!s_q.spi.sck) begin
                        s_d.spi.sck = 1'b1;
                    end else begin
                        s_d.spi.sck = 1'b0;
                        s_d.shreg = {s_q.shreg[38:0], 1'b0};
                        s_d.bit_cnt = s_q.bit_cnt - 6'd1;
                        if (s_q.bit_cnt == 6'd1) begin
                            if (s_q.st == ST_WAKE) begin
                                s_d.spi.cs_n = 1'b1;
                                s_d.wait_cnt = 16'h0000;
                                s_d.st = ST_WAIT;
                            end else begin
                                s_d.rx_bits = 3'd0;
                                s_d.st = ST_LOAD;
                            end
                        end
                    end
                end
                s_d.spi.mosi = s_d.shreg[39];
            end
            ST_WAIT: begin
                s_d.wait_cnt = s_q.wait_cnt + 16'h0001;
                if (s_q.wait_cnt == 16'(WAKE_WAIT_CYCLES)) begin
                    // fast read at zero plus dummy
                    s_d.shreg = {`OP_FAST_READ, `FLASH_START_ADDR, 8'h00};
                    s_d.bit_cnt = `READ_HDR_BITS;
                    s_d.spi.cs_n = 1'b0;
                    s_d.spi.mosi = s_d.shreg[39];
                    s_d.st = ST_CMD;
                end
            end
            ST_LOAD: begin
                s_d.mask_pend = 1'b0;
                if (s_q.in_cnt == 16'(IMAGE_BYTES)) begin
                    s_d.spi = spi_idle();
                    if (!f_out_valid) s_d.st = ST_DONE;
                end else if (s_q.mode == `MODE_ACTIVE) begin
                    // sample flash data, stall clock when buffer full
                    if (tick && f_in_ready) begin
                        s_d.spi.sck = !s_q.spi.sck;
                        if (!s_q.spi.sck) begin
                            s_d.rx = {s_q.rx[6:0], SPI_MISO};
                            s_d.rx_bits = s_q.rx_bits + 3'd1;
                            s_d.bit_cnt = (s_q.rx_bits == 3'd7) ? 6'd1 : 6'd0;
                        end
                    end
                end else if (s_q.mode == `MODE_PASSIVE) begin
                    if (!PAS_CS_N && PAS_SCK && !s_q.pas_sck_prev) begin
                        s_d.rx = {s_q.rx[6:0], PAS_MOSI};
                        s_d.rx_bits = s_q.rx_bits + 3'd1;
                        s_d.bit_cnt = (s_q.rx_bits == 3'd7) ? 6'd1 : 6'd0;
                    end
                end else if (s_q.mode == `MODE_MASK) begin
                    if (!s_q.mask_pend && f_in_ready) begin
                        s_d.mask_pend = 1'b1;
                    end
                end
                if (s_q.mode == `MODE_MASK && s_q.mask_pend) s_d.mask_pend = 1'b0;
            end
            ST_DONE: begin
                // user mode only after full load
                s_d.user = 1'b1;
                if (CONFIG_RESET_N && !s_q.creset_prev) begin
                    s_d.user = 1'b0;
                    s_d.hold = 3'd0;
                    s_d.st = ST_IDLE;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.spi <= spi_idle();
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state flops
    assign SPI_OUT = s_q.spi;
    assign CONFIG_RAM_WR = s_q.wr;
    assign USER_MODE = s_q.user;
    assign MASK_ADDR = s_q.in_cnt;

    // ****************************************
    // checks
    // ****************************************
    // user mode after full load
    a_user_after_load: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        $rose(USER_MODE) |-> s_q.out_cnt == 16'(IMAGE_BYTES))
        else $error("user mode before full load");
    a_no_early_user: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        USER_MODE |-> s_q.st == ST_DONE)
        else $error("user mode outside done state");
    a_start_level: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.st != ST_IDLE && $past(s_q.st) == ST_IDLE |-> $past(CONFIG_RESET_N))
        else $error("start without config reset high");
    // start after the full hold count
    a_start_hold: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.st != ST_IDLE && $past(s_q.st) == ST_IDLE
        |-> $past(s_q.hold) == 3'(`RESET_HOLD_CYCLES))
        else $error("start before hold count");
    // deselected flash sees a low clock
    a_sck_parked: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        SPI_OUT.cs_n |-> !SPI_OUT.sck)
        else $error("serial clock high while deselected");
    // data moves only while the clock is low
    a_mosi_settled: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        $changed(SPI_OUT.mosi) && !SPI_OUT.cs_n |-> !SPI_OUT.sck)
        else $error("data changed with serial clock high");
    // clock edges come from the divider
    a_sck_rate: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        $changed(SPI_OUT.sck) |-> $past(tick))
        else $error("serial clock not from divider");
    a_wake_first: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.st == ST_WAKE && $past(s_q.st) == ST_IDLE
        |-> s_q.shreg[39:32] == `OP_WAKE)
        else $error("first opcode not wake");
    // flash released after the wake byte
    a_wake_released: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.st == ST_WAIT && $past(s_q.st) == ST_WAKE |-> SPI_OUT.cs_n && !SPI_OUT.sck)
        else $error("flash still driven after wake");
    a_wake_gap_held: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.st == ST_WAIT |-> SPI_OUT.cs_n)
        else $error("flash selected during wake wait");
    // full wait length before the read
    a_wait_length: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.st == ST_CMD && $past(s_q.st) == ST_WAIT
        |-> $past(s_q.wait_cnt) == 16'(WAKE_WAIT_CYCLES))
        else $error("wake wait too short");
    // fast read header from address zero
    a_read_cmd: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.st == ST_CMD && $past(s_q.st) == ST_WAIT
        |-> s_q.shreg == {`OP_FAST_READ, `FLASH_START_ADDR, 8'h00})
        else $error("bad fast read header");
    a_write_order: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CONFIG_RAM_WR.we |-> CONFIG_RAM_WR.addr == s_q.out_cnt - 16'h0001)
        else $error("config_ram write out of order");
    // passive load leaves the flash pins parked
    a_passive_quiet: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.mode == `MODE_PASSIVE && s_q.st == ST_LOAD |-> SPI_OUT.cs_n && !SPI_OUT.sck)
        else $error("device drives flash in passive mode");
    // mask option never selects the flash
    a_mask_no_flash: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.mode == `MODE_MASK && s_q.st == ST_LOAD |-> SPI_OUT.cs_n)
        else $error("flash used with mask option");
    // main scenarios reached
    c_active_done: cover property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.mode == `MODE_ACTIVE && $rose(USER_MODE));
    c_passive_done: cover property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.mode == `MODE_PASSIVE && $rose(USER_MODE));
    c_jtag_done: cover property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.mode == `MODE_JTAG && $rose(USER_MODE));
    c_mask_done: cover property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.mode == `MODE_MASK && $rose(USER_MODE));
    c_fifo_full: cover property (@(posedge SYS_CLK) disable iff (!NRST) !f_in_ready);
endmodule

/* File: spi_flash_model.sv */
`timescale 1ns/1ps
// ********
// serial flash stand-in
// ********
module spi_flash_model #(
    parameter logic [7:0] FIRST_BYTE = 8'h3C
) (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic [7:0] wake_byte,
    output logic [39:0] read_hdr
);
    logic [39:0] sh;
    logic [7:0] b;
    int nbits;
    int k;
    initial begin
        miso = 1'b0;
        sh = 40'h00_0000_0000;
        nbits = 0;
        wake_byte = 8'h00;
        read_hdr = 40'h00_0000_0000;
    end
    // shift command bits in while selected
    always @(posedge sck) begin
        if (!cs_n) begin
            sh = {sh[38:0], mosi};
            nbits = nbits + 1;
            if (nbits == 40) begin
                read_hdr = sh;
            end
        end
    end
    // keep a lone byte as the wake command; released line shows the inverse
    always @(posedge cs_n) begin
        if (nbits == 8) begin
            wake_byte = sh[7:0];
        end
        nbits = 0;
        miso = ~miso;
    end
    always @(negedge sck) begin
        if (!cs_n && nbits >= 40) begin
            k = nbits - 40;
            b = FIRST_BYTE + 8'(8'h11 * (k / 8));
            miso = b[7 - k % 8];
        end
    end
endmodule

/* File: tb_spi_config_loader.sv */
`timescale 1ns/1ps
`include "loader_regs.svh"
// ********
// loader bench
// ********
module tb_spi_config_loader;
    import loader_pkg::*;
    localparam int W = 5;
    localparam int N = 4;
    logic SYS_CLK = 1'b0, NRST = 1'b0, CONFIG_RESET_N = 1'b0;
    logic [1:0] MODE = 2'h0;
    logic PAS_SCK = 1'b0, PAS_CS_N = 1'b1, PAS_MOSI = 1'b0, JTAG_VALID = 1'b0;
    logic [7:0] JTAG_BYTE = 8'h00, MASK_BYTE, wake_byte;
    logic [15:0] MASK_ADDR;
    logic [39:0] read_hdr;
    logic SPI_MISO, USER_MODE, cs_q = 1'b1;
    spi_out_t SPI_OUT;
    config_ram_wr_t CONFIG_RAM_WR;
    config_ram_wr_t wq[$];
    int rises[$], falls[$];
    int cyc = 0, bad_count = 0, comparisons = 0;
    // free running system clock
    initial begin
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end
    // on-chip image memory answers from the address
    assign MASK_BYTE = 8'h96 + 8'h11 * MASK_ADDR[7:0];
    config_loader #(.WAKE_WAIT_CYCLES(W), .IMAGE_BYTES(N), .SCK_DIV(2)) config_loader_inst (
        .SYS_CLK(SYS_CLK), .NRST(NRST), .CONFIG_RESET_N(CONFIG_RESET_N), .MODE(MODE),
        .SPI_OUT(SPI_OUT), .SPI_MISO(SPI_MISO), .PAS_SCK(PAS_SCK), .PAS_CS_N(PAS_CS_N),
        .PAS_MOSI(PAS_MOSI), .JTAG_VALID(JTAG_VALID), .JTAG_BYTE(JTAG_BYTE),
        .MASK_ADDR(MASK_ADDR), .MASK_BYTE(MASK_BYTE), .CONFIG_RAM_WR(CONFIG_RAM_WR), .USER_MODE(USER_MODE));
    spi_flash_model #(.FIRST_BYTE(8'h3C)) spi_flash_model_inst (.sck(SPI_OUT.sck),
        .cs_n(SPI_OUT.cs_n), .mosi(SPI_OUT.mosi), .miso(SPI_MISO), .wake_byte(wake_byte),
        .read_hdr(read_hdr));
    // log writes and select edges, cut a hang short
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        cs_q <= SPI_OUT.cs_n;
        if (CONFIG_RAM_WR.we === 1'b1) wq.push_back(CONFIG_RAM_WR);
        if (cs_q === 1'b1 && SPI_OUT.cs_n === 1'b0) falls.push_back(cyc);
        if (cs_q === 1'b0 && SPI_OUT.cs_n === 1'b1) rises.push_back(cyc);
        if (cyc == 50000) begin
            bad_count++;
            $display("unexpected at %0t: timeout", $time);
            results();
        end
    end
    function automatic logic [7:0] img(input logic [7:0] s, input int k);
        return s + 8'(8'h11 * k);
    endfunction
    task check_val(input logic [39:0] got, input logic [39:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task check_true(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task start_load(input logic [1:0] m);
        @(negedge SYS_CLK);
        NRST = 1'b0;
        CONFIG_RESET_N = 1'b0;
        MODE = m;
        repeat (12) @(negedge SYS_CLK);
        wq.delete();
        rises.delete();
        falls.delete();
        NRST = 1'b1;
        CONFIG_RESET_N = 1'b1;
    endtask
    task finish_load(input logic [7:0] s);
        int i;
        // bench side starts nothing new until user mode or 4000 cycles
        for (i = 0; i < 4000 && USER_MODE !== 1'b1; i++) @(negedge SYS_CLK);
        check_true(USER_MODE === 1'b1, "user mode");
        check_val(wq.size(), N, "write count");
        for (i = 0; i < wq.size(); i++) begin
            check_val(wq[i].addr, i, "write addr");
            check_val(wq[i].data, img(s, i), "write data");
        end
    endtask
    task test_active;
        int i;
        start_load(`MODE_ACTIVE);
        for (i = 0; i < 400 && falls.size() < 2; i++) @(negedge SYS_CLK);
        check_true(USER_MODE === 1'b0, "early user mode");
        check_val(wake_byte, `OP_WAKE, "wake opcode");
        check_true(falls.size() == 2 && falls[1] - rises[0] >= W, "wake wait");
        finish_load(8'h3C);
        check_val(read_hdr, {`OP_FAST_READ, `FLASH_START_ADDR, 8'h00}, "read hdr");
        check_true(SPI_OUT.cs_n === 1'b1, "flash released");
    endtask
    task test_passive;
        int b, j;
        logic [7:0] v;
        start_load(`MODE_PASSIVE);
        repeat (8) @(negedge SYS_CLK);
        PAS_CS_N = 1'b0;
        for (b = 0; b < N; b++) begin
            v = img(8'h5A, b);
            for (j = 7; j >= 0; j--) begin
                PAS_MOSI = v[j];
                repeat (2) @(negedge SYS_CLK);
                PAS_SCK = 1'b1;
                repeat (2) @(negedge SYS_CLK);
                PAS_SCK = 1'b0;
            end
        end
        repeat (2) @(negedge SYS_CLK);
        PAS_CS_N = 1'b1;
        PAS_MOSI = ~PAS_MOSI;
        finish_load(8'h5A);
        check_true(falls.size() == 0, "flash untouched");
    endtask
    task test_jtag;
        int b;
        start_load(`MODE_JTAG);
        repeat (8) @(negedge SYS_CLK);
        for (b = 0; b < N; b++) begin
            JTAG_BYTE = img(8'h69, b);
            JTAG_VALID = 1'b1;
            @(negedge SYS_CLK);
            JTAG_VALID = 1'b0;
            repeat (3) @(negedge SYS_CLK);
        end
        finish_load(8'h69);
    endtask
    task test_mask;
        start_load(`MODE_MASK);
        finish_load(8'h96);
        check_true(falls.size() == 0, "no flash read");
    endtask
    // one byte on every cycle through the boundary-scan path
    task jtag_burst(input logic [7:0] s);
        int b;
        JTAG_VALID = 1'b1;
        for (b = 0; b < N; b++) begin
            JTAG_BYTE = img(s, b);
            @(negedge SYS_CLK);
        end
        JTAG_VALID = 1'b0;
    endtask
    task test_burst;
        start_load(`MODE_JTAG);
        repeat (8) @(negedge SYS_CLK);
        // back-to-back bytes pass the buffer with no loss
        jtag_burst(8'hC3);
        repeat (4) @(negedge SYS_CLK);
        check_val(wq.size(), N, "burst writes");
        check_true(USER_MODE === 1'b1, "burst user mode");
        finish_load(8'hC3);
        check_val(MASK_ADDR, N, "burst byte count");
        // rising config reset from done starts a fresh load
        CONFIG_RESET_N = 1'b0;
        @(negedge SYS_CLK);
        wq.delete();
        CONFIG_RESET_N = 1'b1;
        repeat (2) @(negedge SYS_CLK);
        check_true(USER_MODE === 1'b0, "restart clears user mode");
        repeat (8) @(negedge SYS_CLK);
        jtag_burst(8'h24);
        finish_load(8'h24);
    endtask
    task results;
        $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        test_active();
        test_passive();
        test_jtag();
        test_mask();
        test_burst();
        results();
    end
endmodule
